// ### hw/anp_defines.svh
// Register map, field positions and reset values for the next page slice.
// Assumes a 16-bit management register file addressed by 5-bit number.
`ifndef ANP_DEFINES_SVH
`define ANP_DEFINES_SVH
`define ANP_ADDR_TX_NP 5'h07
`define ANP_ADDR_RX_NP 5'h08
`define ANP_ADDR_LF_STAT 5'h0A
`define ANP_ADDR_EXP 5'h06
`define ANP_TX_NP_RESET 16'h2001
`define ANP_RX_NP_RESET 16'h0000
`define ANP_TX_WR_MASK 16'hB7FF
`define ANP_EXP_FIXED 16'h0064
`define ANP_BIT_MORE 15
`define ANP_BIT_ACK 14
`define ANP_BIT_MSG 13
`define ANP_BIT_ACK2 12
`define ANP_BIT_TOG 11
`define ANP_BIT_LOC_OK 13
`define ANP_BIT_REM_OK 12
`define ANP_BIT_FD1000 11
`define ANP_BIT_HD1000 10
`define ANP_BIT_PAGE_RX 1
`endif

// ### hw/anp_idle_cnt.sv
// Saturating idle error counter.
// Assumes one-cycle error pulses synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module anp_idle_cnt #(
   parameter int WIDTH = 8
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic idle_err,
   output logic [WIDTH-1:0] count
);
   logic [WIDTH-1:0] count_reg;
   logic [WIDTH-1:0] count_next;
   // Saturate rather than wrap so a flood of errors never reads as few.
   assign count_next = (&count_reg) ? count_reg : count_reg + 1'b1;
   assign count = count_reg;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) count_reg <= '0;
      else if (idle_err) count_reg <= count_next;
   end
   chk_count_step_up: assert property (
      @(posedge mclk) disable iff (rst)
      idle_err && !(&count_reg) |=> count_reg == $past(count_reg) + 1'b1)
      else $error("idle count did not step");
endmodule // anp_idle_cnt
`default_nettype wire

// ### hw/anp_pkg.sv
// Types shared by the next page register slice.
// Assumes the defines header is compiled alongside.
package anp_pkg;
   typedef logic [15:0] anp_word_t;
   typedef logic [4:0] anp_addr_t;
endpackage

// ### hw/anp_rd_if.sv
// Read-side carrier between the register bank and its read mux.
// Assumes a single clock domain.
`timescale 1ns/1ps
`default_nettype none
interface anp_rd_if;
   logic [15:0] tx_np;
   logic [15:0] rx_np;
   logic [15:0] lf_stat;
   logic [15:0] exp;
   modport bank (output tx_np, output rx_np, output lf_stat, output exp);
   modport mux (input tx_np, input rx_np, input lf_stat, input exp);
endinterface
`default_nettype wire

// ### hw/anp_rd_mux.sv
// Registered read data selection for the management read port.
// Assumes the address is stable during the read strobe.
`timescale 1ns/1ps
`default_nettype none
`include "anp_defines.svh"
module anp_rd_mux (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [4:0] addr,
   anp_rd_if.mux rd,
   output logic [15:0] rdata
);
   logic [15:0] sel;
   logic [15:0] rdata_reg;
   // Unmapped addresses read as zero.
   assign sel = (addr == `ANP_ADDR_TX_NP) ? rd.tx_np :
                (addr == `ANP_ADDR_RX_NP) ? rd.rx_np :
                (addr == `ANP_ADDR_LF_STAT) ? rd.lf_stat :
                (addr == `ANP_ADDR_EXP) ? rd.exp : 16'h0000;
   assign rdata = rdata_reg;
   // Data is registered so the top output comes from a flip-flop.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) rdata_reg <= 16'h0000;
      else rdata_reg <= sel;
   end
endmodule // anp_rd_mux
`default_nettype wire

// ### hw/anp_regs.sv
// Next page transmit/receive and leader/follower status registers.
// Assumes a management frame engine supplies address, write and read
// strobes, and the arbitration logic supplies page events.
// Overview of operation
// - transmit page at 0x07, reset 0x2001
// - bit 15 says more pages follow
// - bit 13 message page, reset one
// - bit 12 says local can comply
// - bit 11 toggle inverts previous word's
// - bits 10:0 writable code, reset one
// - received bit 15 partner more pages
// - received bit 14 handshake only, ignore
// - received bit 13 partner message page
// - received bit 12 partner can comply
// - received bit 11 partner toggle bit
// - received bits 10:0 partner code, reset zero
// - status bit 13 local receiver ok
// - status bit 12 remote receiver ok
// - status bit 11 partner gigabit full duplex
// - status bit 10 partner gigabit half duplex
// - status bits 7:0 idle error count
// - page received latch clears on read
// - next pages stored at address 0x08
`timescale 1ns/1ps
`default_nettype none
`include "anp_defines.svh"
module anp_regs #(
   parameter int CNT_WIDTH = 8
) (
   input wire logic mclk,
   input wire logic rst,
   input wire anp_pkg::anp_addr_t reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire anp_pkg::anp_word_t reg_wdata,
   output logic [15:0] reg_rdata,
   input wire logic page_rx_valid,
   input wire anp_pkg::anp_word_t page_rx_word,
   input wire logic page_tx_done,
   input wire logic local_receiver_ok,
   input wire logic remote_receiver_ok,
   input wire logic partner_gigabit_full_duplex,
   input wire logic partner_gigabit_half_duplex,
   input wire logic idle_err,
   output logic [15:0] tx_page_word
);
   import anp_pkg::*;

   anp_rd_if rd ();
   anp_word_t tx_np_reg;
   anp_word_t rx_np_reg;
   logic page_received_latch_reg;
   logic page_received_latch_next;
   logic page_toggle_reg;
   logic [1:0] status_reg;
   logic [1:0] partner_gig_reg;
   logic [15:0] tx_page_word_reg;
   logic [CNT_WIDTH-1:0] idle_error_counter;
   logic tx_wr;
   logic exp_rd;
   anp_word_t tx_view;

   // Address decode for the writable and read-sensitive registers.
   assign tx_wr = reg_wr && (reg_addr == `ANP_ADDR_TX_NP);
   assign exp_rd = reg_rd && (reg_addr == `ANP_ADDR_EXP);

   assign tx_view = {tx_np_reg[15:12], page_toggle_reg, tx_np_reg[10:0]};

   // code field writable
   // Bits 14 and 11 are masked so a write cannot disturb them.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) tx_np_reg <= `ANP_TX_NP_RESET & `ANP_TX_WR_MASK;
      else if (tx_wr) tx_np_reg <= reg_wdata & `ANP_TX_WR_MASK;
   end

   // toggle flips per word
   // The toggle starts at zero and inverts after each exchanged word.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) page_toggle_reg <= 1'b0;
      else if (page_tx_done) page_toggle_reg <= ~page_toggle_reg;
   end

   // handshake bit stored
   // Bit 14 is captured as sent; software is told to ignore it.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) rx_np_reg <= `ANP_RX_NP_RESET;
      else if (page_rx_valid) rx_np_reg <= page_rx_word;
   end

   // latch with set priority
   // A page arriving in the read cycle keeps the latch set.
   assign page_received_latch_next = page_rx_valid ? 1'b1 :
                                     exp_rd ? 1'b0 : page_received_latch_reg;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) page_received_latch_reg <= 1'b0;
      else page_received_latch_reg <= page_received_latch_next;
   end

   // receiver and gigabit duplex status
   // Inputs are registered once so reads see a stable snapshot.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         status_reg <= 2'h0;
         partner_gig_reg <= 2'h0;
      end else begin
         status_reg <= {local_receiver_ok, remote_receiver_ok};
         partner_gig_reg <= {partner_gigabit_full_duplex,
                             partner_gigabit_half_duplex};
      end
   end

   // The outgoing word is what the arbitration logic serialises.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) tx_page_word_reg <= 16'h0000;
      else tx_page_word_reg <= tx_view;
   end
   assign tx_page_word = tx_page_word_reg;

   anp_idle_cnt #(
      .WIDTH(CNT_WIDTH)
   ) u_idle (
      .mclk(mclk),
      .rst(rst),
      .idle_err(idle_err),
      .count(idle_error_counter)
   );

   // Read views, reserved bits forced to zero.
   assign rd.tx_np = tx_view;
   assign rd.rx_np = rx_np_reg;
   assign rd.lf_stat = {2'b00, status_reg, partner_gig_reg, 2'b00,
                        idle_error_counter[7:0]};
   assign rd.exp = `ANP_EXP_FIXED |
                   ({15'h0000, page_received_latch_reg} << `ANP_BIT_PAGE_RX);

   anp_rd_mux u_mux (
      .mclk(mclk),
      .rst(rst),
      .addr(reg_addr),
      .rd(rd),
      .rdata(reg_rdata)
   );

   // The reset-edge checks run without a disable so they see release.
   // reset view of page
   chk_tx_reset_value: assert property (
      @(posedge mclk)
      $fell(rst) |-> tx_view == `ANP_TX_NP_RESET)
      else $error("transmit page reset wrong");
   chk_tx_hold: assert property (
      @(posedge mclk) disable iff (rst)
      !tx_wr |=> $stable(tx_np_reg))
      else $error("transmit page moved without a write");
   chk_tx_word_copy: assert property (
      @(posedge mclk) disable iff (rst)
      1'b1 |=> tx_page_word == $past(tx_view))
      else $error("outgoing word does not follow the register");
   chk_tx_read_path: assert property (
      @(posedge mclk) disable iff (rst)
      reg_addr == `ANP_ADDR_TX_NP |=> reg_rdata == $past(tx_view))
      else $error("transmit page read mismatch");
   chk_tx_write_bits: assert property (
      @(posedge mclk) disable iff (rst)
      tx_wr |=> tx_np_reg[15] == $past(reg_wdata[15]) &&
         tx_np_reg[13:12] == $past(reg_wdata[13:12]))
      else $error("control bits not written");
   chk_tx_code_write: assert property (
      @(posedge mclk) disable iff (rst)
      tx_wr |=> tx_np_reg[10:0] == $past(reg_wdata[10:0]))
      else $error("code field not written");
   chk_toggle_flip: assert property (
      @(posedge mclk) disable iff (rst)
      page_tx_done |=> tx_view[11] != $past(tx_view[11]))
      else $error("toggle did not invert");
   chk_toggle_hold: assert property (
      @(posedge mclk) disable iff (rst)
      !page_tx_done && !tx_wr |=> $stable(tx_view))
      else $error("toggle moved without a word");
   chk_toggle_ro: assert property (
      @(posedge mclk) disable iff (rst)
      tx_wr && !page_tx_done |=> tx_view[11] == $past(tx_view[11]))
      else $error("write disturbed the toggle");
   chk_rx_capture_all: assert property (
      @(posedge mclk) disable iff (rst)
      page_rx_valid |=> rx_np_reg == $past(page_rx_word) &&
         page_received_latch_reg)
      else $error("received page not captured");
   chk_rx_more_flag: assert property (
      @(posedge mclk) disable iff (rst)
      page_rx_valid |=> rx_np_reg[15] == $past(page_rx_word[15]))
      else $error("partner more pages bit wrong");
   chk_rx_ack_kept: assert property (
      @(posedge mclk) disable iff (rst)
      page_rx_valid |=> rx_np_reg[14] == $past(page_rx_word[14]))
      else $error("partner handshake bit wrong");
   chk_rx_msg_flag: assert property (
      @(posedge mclk) disable iff (rst)
      page_rx_valid |=> rx_np_reg[13] == $past(page_rx_word[13]))
      else $error("partner message page bit wrong");
   chk_rx_comply_flag: assert property (
      @(posedge mclk) disable iff (rst)
      page_rx_valid |=> rx_np_reg[12] == $past(page_rx_word[12]))
      else $error("partner comply bit wrong");
   chk_rx_toggle_kept: assert property (
      @(posedge mclk) disable iff (rst)
      page_rx_valid |=> rx_np_reg[11] == $past(page_rx_word[11]))
      else $error("partner toggle bit wrong");
   chk_rx_code_kept: assert property (
      @(posedge mclk) disable iff (rst)
      page_rx_valid |=> rx_np_reg[10:0] == $past(page_rx_word[10:0]))
      else $error("partner code field wrong");
   chk_rx_reset_zero: assert property (
      @(posedge mclk)
      $fell(rst) |-> rx_np_reg == `ANP_RX_NP_RESET)
      else $error("received page reset wrong");
   chk_rx_hold: assert property (
      @(posedge mclk) disable iff (rst)
      !page_rx_valid |=> $stable(rx_np_reg))
      else $error("received page moved without a page");
   chk_rx_read_path: assert property (
      @(posedge mclk) disable iff (rst)
      reg_addr == `ANP_ADDR_RX_NP |=> reg_rdata == $past(rx_np_reg))
      else $error("received page read mismatch");
   chk_latch_hold: assert property (
      @(posedge mclk) disable iff (rst)
      page_received_latch_reg && !exp_rd |=> page_received_latch_reg)
      else $error("latch dropped without read");
   chk_latch_clear: assert property (
      @(posedge mclk) disable iff (rst)
      exp_rd && !page_rx_valid |=> !page_received_latch_reg)
      else $error("latch not cleared by read");
   chk_latch_quiet: assert property (
      @(posedge mclk) disable iff (rst)
      !page_received_latch_reg && !page_rx_valid |=>
         !page_received_latch_reg)
      else $error("latch set without a page");
   chk_exp_latch_bit: assert property (
      @(posedge mclk) disable iff (rst)
      reg_addr == `ANP_ADDR_EXP |=>
         reg_rdata[1] == $past(page_received_latch_reg))
      else $error("page received bit read mismatch");
   chk_local_status: assert property (
      @(posedge mclk) disable iff (rst)
      1'b1 |=> rd.lf_stat[13] == $past(local_receiver_ok))
      else $error("local receiver bit wrong");
   chk_remote_status: assert property (
      @(posedge mclk) disable iff (rst)
      1'b1 |=> rd.lf_stat[12] == $past(remote_receiver_ok))
      else $error("remote receiver bit wrong");
   chk_gig_full: assert property (
      @(posedge mclk) disable iff (rst)
      1'b1 |=> rd.lf_stat[11] == $past(partner_gigabit_full_duplex))
      else $error("partner full duplex bit wrong");
   chk_gig_half: assert property (
      @(posedge mclk) disable iff (rst)
      1'b1 |=> rd.lf_stat[10] == $past(partner_gigabit_half_duplex))
      else $error("partner half duplex bit wrong");
   chk_status_read: assert property (
      @(posedge mclk) disable iff (rst)
      reg_addr == `ANP_ADDR_LF_STAT |=> reg_rdata == $past(rd.lf_stat))
      else $error("status read mismatch");
   chk_count_hold: assert property (
      @(posedge mclk) disable iff (rst)
      !idle_err |=> $stable(rd.lf_stat[7:0]))
      else $error("idle count moved without an error");
   // Main scenarios that the bench is meant to reach.
   cov_page_rx: cover property (@(posedge mclk) disable iff (rst)
      page_rx_valid ##[1:20] exp_rd);
   cov_tx_write: cover property (@(posedge mclk) disable iff (rst)
      tx_wr ##1 page_tx_done);
   cov_set_wins: cover property (@(posedge mclk) disable iff (rst)
      page_rx_valid && exp_rd);
   cov_count_full: cover property (@(posedge mclk) disable iff (rst)
      idle_err && (&idle_error_counter));
   cov_toggle_pair: cover property (@(posedge mclk) disable iff (rst)
      page_tx_done ##[1:20] page_tx_done);
endmodule // anp_regs
`default_nettype wire

// ### tb/anp_lp_model.sv
// Link partner stand-in: hands next pages and exchange events to the PHY.
// Assumes its tasks are called at the falling edge of mclk.
`timescale 1ns/1ps
`default_nettype none
module anp_lp_model (
   input wire logic mclk,
   output logic page_rx_valid,
   output anp_pkg::anp_word_t page_rx_word,
   output logic page_tx_done
);
   import anp_pkg::*;
   logic tog = 1'b0;
   // Quiet outputs from time zero.
   initial begin
      page_rx_valid = 1'b0;
      page_rx_word = 16'h5A5A;
      page_tx_done = 1'b0;
   end
   // The word stands for its valid cycle only, then shows its inverse,
   // so a late capture in the PHY cannot pass by luck.
   // partner word fields
   task automatic send_page(input logic more, input logic msg,
         input logic ack2, input logic [10:0] code, output anp_word_t w);
      w = {more, 1'b1, msg, ack2, tog, code};
      page_rx_valid = 1'b1;
      page_rx_word = w;
      tog = ~tog;
      @(negedge mclk);
      page_rx_valid = 1'b0;
      page_rx_word = ~w;
   endtask
   // One completed link code word exchange.
   task automatic exchange();
      page_tx_done = 1'b1;
      @(negedge mclk);
      page_tx_done = 1'b0;
   endtask
endmodule // anp_lp_model
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the next page register slice.
// Assumes reads show the register addressed one cycle earlier.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import anp_pkg::*;
   typedef struct {
      logic wr;
      anp_addr_t a;
      anp_word_t wd;
      anp_word_t ex;
   } anp_row_t;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   anp_addr_t reg_addr = 5'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   anp_word_t reg_wdata = 16'h0000;
   logic [15:0] reg_rdata;
   logic [15:0] tx_page_word;
   logic page_rx_valid;
   logic page_tx_done;
   logic idle_err = 1'b0;
   anp_word_t page_rx_word;
   anp_word_t w;
   logic [3:0] lvl = 4'h0;
   int n_fail = 0;
   int samples_checked = 0;
   // Write rows then read back; unmapped and read-only places included.
   anp_row_t rows [9] = '{'{1'b0, 5'h07, 16'h0000, 16'h2001},
      '{1'b0, 5'h08, 16'h0000, 16'h0000}, '{1'b0, 5'h0A, 16'h0000, 16'h0000},
      '{1'b0, 5'h06, 16'h0000, 16'h0064}, '{1'b0, 5'h1F, 16'h0000, 16'h0000},
      '{1'b1, 5'h07, 16'hFFFF, 16'hB7FF}, '{1'b1, 5'h08, 16'hFFFF, 16'h0000},
      '{1'b1, 5'h0A, 16'hFFFF, 16'h0000}, '{1'b1, 5'h07, 16'h0000, 16'h0000}};
   always #4 mclk = ~mclk;
   anp_regs #(.CNT_WIDTH(8)) u_dut (.mclk(mclk), .rst(rst),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .page_rx_valid(page_rx_valid), .page_rx_word(page_rx_word),
      .page_tx_done(page_tx_done), .local_receiver_ok(lvl[3]),
      .remote_receiver_ok(lvl[2]), .partner_gigabit_full_duplex(lvl[1]),
      .partner_gigabit_half_duplex(lvl[0]), .idle_err(idle_err),
      .tx_page_word(tx_page_word));
   anp_lp_model u_lp (.mclk(mclk), .page_rx_valid(page_rx_valid),
      .page_rx_word(page_rx_word), .page_tx_done(page_tx_done));
   task automatic chk(input logic [15:0] got, input logic [15:0] ex);
      samples_checked++;
      if (got !== ex) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got %h want %h", $time, got, ex);
      end
   endtask
   task automatic wr(input anp_addr_t a, input anp_word_t d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge mclk);
      reg_wr = 1'b0;
   endtask
   // Read data lands one edge after the address, so compare a cycle on.
   // The strobe stands until the next read sets it, so back-to-back
   // reads never write it twice in one time step.
   task automatic rd(input anp_addr_t a, input logic s, input anp_word_t ex);
      reg_addr = a;
      reg_rd = s;
      @(negedge mclk);
      chk(reg_rdata, ex);
   endtask
   task automatic errs(input int n);
      repeat (n) begin
         idle_err = 1'b1;
         @(negedge mclk);
         idle_err = 1'b0;
         @(negedge mclk);
      end
   endtask
   task automatic stop_test();
      $display("TB: mismatches %0d, checks %0d", n_fail, samples_checked);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // The whole run needs about 660 cycles; this bound cuts a hang.
   initial begin
      #80000;
      n_fail++;
      stop_test();
   end
   initial begin
      repeat (20) @(negedge mclk);
      chk(tx_page_word, 16'h0000);
      rst = 1'b0;
      @(negedge mclk);
      chk(tx_page_word, 16'h2001);
      foreach (rows[i]) begin
         if (rows[i].wr) begin
            wr(rows[i].a, rows[i].wd);
         end
         rd(rows[i].a, 1'b0, rows[i].ex);
      end
      u_lp.exchange();
      rd(5'h07, 1'b0, 16'h0800);
      chk(tx_page_word, 16'h0800);
      u_lp.send_page(1'b1, 1'b1, 1'b0, 11'h5A5, w);
      rd(5'h08, 1'b0, w);
      rd(5'h06, 1'b1, 16'h0066);
      rd(5'h06, 1'b0, 16'h0064);
      // A page landing in the clearing read cycle must keep the latch.
      fork
         u_lp.send_page(1'b0, 1'b0, 1'b1, 11'h7FF, w);
         rd(5'h06, 1'b1, 16'h0064);
      join
      rd(5'h06, 1'b0, 16'h0066);
      rd(5'h08, 1'b0, w);
      lvl = 4'hA;
      errs(3);
      rd(5'h0A, 1'b0, 16'h2803);
      lvl = 4'h5;
      errs(300);
      rd(5'h0A, 1'b0, 16'h14FF);
      rst = 1'b1;
      @(negedge mclk);
      rst = 1'b0;
      @(negedge mclk);
      rd(5'h07, 1'b0, 16'h2001);
      rd(5'h08, 1'b0, 16'h0000);
      rd(5'h0A, 1'b0, 16'h1400);
      stop_test();
   end
endmodule // tb_top
`default_nettype wire
